// ==== hw/bkm_pkg.sv ====
// Purpose: Shared constants and types of the breaker and phase rotation monitor
// Assumes: 200 MHz core clock, APB register access with 32-bit data
// Notes:   Timers count whole 10 ms ticks
package bkm_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned TICK_MS          = 10;
    localparam int unsigned TICK_CYCLES      = CLK_MHZ * 1000 * TICK_MS;
    localparam int unsigned CLOSE_HOLD_MS    = 5000;
    localparam int unsigned CLOSE_HOLD_TICKS = (CLOSE_HOLD_MS + TICK_MS - 1) / TICK_MS;
    localparam logic [8:0]  OPEN_TMO_MIN     = 9'h00A;
    localparam logic [8:0]  OPEN_TMO_MAX     = 9'h1F4;
    localparam logic [8:0]  OPEN_TMO_RST     = 9'h0C8;
    localparam logic [3:0]  ATTEMPT_MIN      = 4'h1;
    localparam logic [3:0]  ATTEMPT_MAX      = 4'hA;
    localparam logic [3:0]  ATTEMPT_RST      = 4'h3;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_OPEN_TMO = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_ACK      = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // Alarm classes, rotation alarm uses all, breaker alarm only A or B
    typedef enum logic [2:0] {
        CLS_A = 3'h0, CLS_B = 3'h1, CLS_C = 3'h2, CLS_D = 3'h3,
        CLS_E = 3'h4, CLS_F = 3'h5, CLS_CONTROL = 3'h6
    } bkm_class_t;

    // Control register layout, bit 19 downward
    typedef struct packed {
        logic [3:0] maxAttempts;      // 19:16
        logic [1:0] rsvd;             // 15:14
        logic       brkClassB;        // 13
        bkm_class_t rotClass;         // 12:10
        logic       rsvd1;            // 9
        logic       singleRotReverse; // 8
        logic       singlePhase;      // 7
        logic       brkLockable;      // 6
        logic       brkSelfAck;       // 5
        logic       rotLockable;      // 4
        logic       rotSelfAck;       // 3
        logic       breakerMonEnable; // 2
        logic       rotationReverse;  // 1
        logic       rotMonEnable;     // 0
    } bkm_cfg_t;

    localparam bkm_cfg_t CFG_RST = '{maxAttempts: ATTEMPT_RST, brkClassB: 1'b1, rotClass: CLS_B,
                                     breakerMonEnable: 1'b1, default: '0};

    // Alarm and interrupt bit positions
    localparam int unsigned ALM_ROT   = 0;
    localparam int unsigned ALM_CLOSE = 1;
    localparam int unsigned ALM_OPEN  = 2;
    localparam int unsigned ALM_W     = 3;

    typedef enum logic [2:0] {
        OS_IDLE = 3'b001, OS_TIMING = 3'b010, OS_DONE = 3'b100
    } bkm_open_state_t;
endpackage : bkm_pkg

// ==== hw/bkm_monitor.sv ====
// Purpose: Breaker close/open supervision and system B phase rotation alarm
// Assumes: All inputs synchronous to core_clk; feedback high means breaker open
// Notes:   Registers over APB, one wait state per transfer
//
// Overview of operation
// - Rotation checked only while rotation enable set; enable resets off.
// - Expected rotation forward (reset) or reverse is configurable.
// - Rotation and breaker alarms carry separate classes; rotation class A to F or Control.
// - Self-acknowledge clears alarm as soon as fault disappears.
// - Otherwise alarm stays latched until manual or external acknowledge.
// - Lockable monitoring checks only while lock input is low.
// - Breaker supervision runs only while breaker enable set; resets on.
// - Issued close commands counted against maximum of 1 to 10.
// - Counter at maximum raises close failure alarm.
// - Counter cleared after feedback low continuously for 5 seconds.
// - Open timer starts with each open sequence; 0.10 to 5.00 s, reset 2.00 s.
// - Feedback still low at timer expiry raises open failure alarm.
// - Breaker alarms use breaker class A or B, reset B.
// - Measured rotation differing from expected raises rotation alarm.
// - Three-phase: evaluate above half voltage; single-phase: take configured rotation.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module bkm_monitor import bkm_pkg::*; #(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        closeRequest,
    input  wire logic        openRequest,
    input  wire logic        breakerOpenFeedback,
    input  wire logic        lockMonitoring,
    input  wire logic        extAck,
    input  wire logic        measuredReverse,
    input  wire logic        voltageAboveHalf,
    output logic             breakerCloseCommand,
    output logic             breakerOpenCommand,
    output logic [ALM_W-1:0] alarms,
    output bkm_class_t       rotAlarmClass,
    output bkm_class_t       brkAlarmClass,
    output logic             irq
);
    // ==========================================================
    // Helpers
    function automatic logic alarm_next(input logic cur, input logic fault, input logic selfAck,
                                        input logic ack);
        if (selfAck) begin
            return fault;
        end
        return fault | (cur & ~ack);
    endfunction : alarm_next

    function automatic logic check_on(input logic en, input logic lockable, input logic lock);
        return en & ~(lockable & lock);
    endfunction : check_on

    // ==========================================================
    // Tick generator
    logic [31:0] tickCnt_r, tickCnt_nxt;
    logic        tick_r, tick_nxt;
    always_comb begin
        tickCnt_nxt = tickCnt_r + 32'h1;
        tick_nxt    = 1'b0;
        if (tickCnt_r >= 32'(TICK_LEN - 1)) begin
            tickCnt_nxt = '0;
            tick_nxt    = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tickCnt_r <= '0;
            tick_r    <= 1'b0;
        end else begin
            tickCnt_r <= tickCnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    // ==========================================================
    // APB slave and registers
    bkm_cfg_t         cfg_r, cfg_nxt;
    logic [8:0]       openTmo_r, openTmo_nxt;
    logic [ALM_W-1:0] irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt;
    logic [ALM_W-1:0] alarm_r, alarm_nxt;
    logic             manAck_r, manAck_nxt;
    logic [31:0]      prdata_r, prdata_nxt;
    logic             pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [3:0]       attempts_r;
    logic             wrEn, hit;
    bkm_cfg_t         wcfg;

    always_comb begin
        wcfg        = bkm_cfg_t'(pwdata[$bits(bkm_cfg_t)-1:0]);
        wrEn        = psel & penable & pready_r & pwrite;
        pready_nxt  = psel & penable & ~pready_r;
        hit         = paddr inside {ADDR_CTRL, ADDR_OPEN_TMO, ADDR_STATUS, ADDR_ACK, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
        pslverr_nxt = pready_nxt & ~hit;
        prdata_nxt  = prdata_r;
        cfg_nxt     = cfg_r;
        openTmo_nxt = openTmo_r;
        irqMask_nxt = irqMask_r;
        manAck_nxt  = 1'b0;
        if (pready_nxt && !pwrite) begin
            case (paddr)
                ADDR_CTRL:     prdata_nxt = 32'(cfg_r);
                ADDR_OPEN_TMO: prdata_nxt = 32'(openTmo_r);
                ADDR_STATUS:   prdata_nxt = {20'h0, attempts_r, 5'h0, alarm_r};
                ADDR_IRQ_STAT: prdata_nxt = 32'(irqStat_r);
                ADDR_IRQ_MASK: prdata_nxt = 32'(irqMask_r);
                default:       prdata_nxt = 32'h0;
            endcase
        end
        if (wrEn) begin
            case (paddr)
                ADDR_CTRL: begin
                    cfg_nxt = wcfg;
                    cfg_nxt.rsvd  = '0;
                    cfg_nxt.rsvd1 = 1'b0;
                    if (wcfg.rotClass > CLS_CONTROL) cfg_nxt.rotClass = cfg_r.rotClass;
                    if (wcfg.maxAttempts < ATTEMPT_MIN || wcfg.maxAttempts > ATTEMPT_MAX) begin
                        cfg_nxt.maxAttempts = cfg_r.maxAttempts;
                    end
                end
                ADDR_OPEN_TMO: begin
                    if (pwdata[8:0] >= OPEN_TMO_MIN && pwdata[8:0] <= OPEN_TMO_MAX) begin
                        openTmo_nxt = pwdata[8:0];
                    end
                end
                ADDR_ACK:      manAck_nxt  = pwdata[0];
                ADDR_IRQ_MASK: irqMask_nxt = pwdata[ALM_W-1:0];
                default:       ;
            endcase
        end
        // New alarm edges win over a same-cycle write-one-to-clear
        irqStat_nxt = irqStat_r;
        if (wrEn && paddr == ADDR_IRQ_STAT) irqStat_nxt = irqStat_r & ~pwdata[ALM_W-1:0];
        irqStat_nxt = irqStat_nxt | (alarm_nxt & ~alarm_r);
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_r     <= CFG_RST;
            openTmo_r <= OPEN_TMO_RST;
            irqStat_r <= '0;
            irqMask_r <= '0;
            manAck_r  <= 1'b0;
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            openTmo_r <= openTmo_nxt;
            irqStat_r <= irqStat_nxt;
            irqMask_r <= irqMask_nxt;
            manAck_r  <= manAck_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ==========================================================
    // Close attempt counter and feedback debounce
    logic [3:0]  attempts_nxt;
    logic [15:0] lowTicks_r, lowTicks_nxt;
    logic        closeCmd_r, openCmd_r;
    logic        brkCheck;
    always_comb begin
        brkCheck     = check_on(cfg_r.breakerMonEnable, cfg_r.brkLockable, lockMonitoring);
        attempts_nxt = attempts_r;
        lowTicks_nxt = lowTicks_r;
        if (breakerOpenFeedback) begin
            lowTicks_nxt = '0;
        end else if (tick_r && lowTicks_r < 16'(CLOSE_HOLD_TICKS)) begin
            lowTicks_nxt = lowTicks_r + 16'h1;
        end
        if (closeRequest && attempts_r != 4'hF) begin
            attempts_nxt = attempts_r + 4'h1;
        end
        if (lowTicks_r >= 16'(CLOSE_HOLD_TICKS)) begin
            attempts_nxt = '0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            attempts_r <= '0;
            lowTicks_r <= '0;
            closeCmd_r <= 1'b0;
            openCmd_r  <= 1'b0;
        end else begin
            attempts_r <= attempts_nxt;
            lowTicks_r <= lowTicks_nxt;
            closeCmd_r <= closeRequest;
            openCmd_r  <= openRequest;
        end
    end

    // ==========================================================
    // Open supervision
    bkm_open_state_t osState_r, osState_nxt;
    logic [8:0]      osTicks_r, osTicks_nxt;
    always_comb begin
        osState_nxt = osState_r;
        osTicks_nxt = osTicks_r;
        case (osState_r)
            OS_IDLE, OS_DONE: begin
                if (openRequest) begin
                    osState_nxt = OS_TIMING;
                    osTicks_nxt = '0;
                end
            end
            OS_TIMING: begin
                if (openRequest) begin
                    osTicks_nxt = '0;
                end else if (breakerOpenFeedback) begin
                    osState_nxt = OS_IDLE;
                end else if (tick_r) begin
                    osTicks_nxt = osTicks_r + 9'h1;
                    if (osTicks_nxt >= openTmo_r) osState_nxt = OS_DONE;
                end
            end
            default: osState_nxt = OS_IDLE;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            osState_r <= OS_IDLE;
            osTicks_r <= '0;
        end else begin
            osState_r <= osState_nxt;
            osTicks_r <= osTicks_nxt;
        end
    end

    // ==========================================================
    // Faults and alarms
    logic             rotCheck, rotMeasRev, ack;
    logic [ALM_W-1:0] fault;
    always_comb begin
        ack        = manAck_r | extAck;
        rotCheck   = check_on(cfg_r.rotMonEnable, cfg_r.rotLockable, lockMonitoring)
                   & (cfg_r.singlePhase | voltageAboveHalf);
        rotMeasRev = cfg_r.singlePhase ? cfg_r.singleRotReverse : measuredReverse;
        fault[ALM_ROT]   = rotCheck & (rotMeasRev != cfg_r.rotationReverse);
        fault[ALM_CLOSE] = brkCheck & (attempts_r >= cfg_r.maxAttempts);
        fault[ALM_OPEN]  = brkCheck & (osState_r == OS_DONE) & ~breakerOpenFeedback;
        alarm_nxt[ALM_ROT]   = alarm_next(alarm_r[ALM_ROT], fault[ALM_ROT], cfg_r.rotSelfAck, ack);
        alarm_nxt[ALM_CLOSE] = alarm_next(alarm_r[ALM_CLOSE], fault[ALM_CLOSE], cfg_r.brkSelfAck, ack);
        alarm_nxt[ALM_OPEN]  = alarm_next(alarm_r[ALM_OPEN], fault[ALM_OPEN], cfg_r.brkSelfAck, ack);
    end
    logic irq_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarm_r <= '0;
            irq_r   <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
            irq_r   <= |(irqStat_nxt & irqMask_nxt);
        end
    end

    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign breakerCloseCommand = closeCmd_r;
    assign breakerOpenCommand  = openCmd_r;
    assign alarms              = alarm_r;
    assign rotAlarmClass       = cfg_r.rotClass;
    // Class A encodes as 0 and B as 1, so the stored bit drives the class with no mux
    assign brkAlarmClass       = bkm_class_t'({2'b00, cfg_r.brkClassB});
    assign irq                 = irq_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_open_start;
        openRequest && osState_r != OS_TIMING;
    endsequence
    property p_rot_off;
        !cfg_r.rotMonEnable |-> !fault[ALM_ROT];
    endproperty
    a_rot_off: assert property (p_rot_off) else $error("rotation fault while disabled");
    property p_rot_mismatch;
        rotCheck && (rotMeasRev != cfg_r.rotationReverse) |=> alarm_r[ALM_ROT];
    endproperty
    a_rot_mismatch: assert property (p_rot_mismatch) else $error("rotation alarm missing");
    property p_self_ack;
        cfg_r.rotSelfAck && !fault[ALM_ROT] |=> !alarm_r[ALM_ROT];
    endproperty
    a_self_ack: assert property (p_self_ack) else $error("self ack did not clear");
    property p_latched;
        !cfg_r.brkSelfAck && alarm_r[ALM_CLOSE] && !ack |=> alarm_r[ALM_CLOSE];
    endproperty
    a_latched: assert property (p_latched) else $error("latched alarm dropped");
    property p_lock;
        cfg_r.brkLockable && lockMonitoring |-> !fault[ALM_CLOSE] && !fault[ALM_OPEN];
    endproperty
    a_lock: assert property (p_lock) else $error("fault while locked");
    property p_close_max;
        cfg_r.breakerMonEnable && !lockMonitoring && attempts_r >= cfg_r.maxAttempts |=> alarm_r[ALM_CLOSE];
    endproperty
    a_close_max: assert property (p_close_max) else $error("close failure not raised");
    property p_clear_cnt;
        lowTicks_r >= 16'(CLOSE_HOLD_TICKS) |=> attempts_r == '0;
    endproperty
    a_clear_cnt: assert property (p_clear_cnt) else $error("attempt counter not cleared");
    property p_open_start;
        s_open_start |=> osState_r == OS_TIMING && osTicks_r == '0;
    endproperty
    a_open_start: assert property (p_open_start) else $error("open timer not started");
    property p_brk_off;
        !cfg_r.breakerMonEnable |-> !fault[ALM_CLOSE] && !fault[ALM_OPEN];
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("breaker fault while disabled");
    property p_tick;
        tick_r |=> !tick_r;
    endproperty
    a_tick: assert property (p_tick) else $error("tick longer than one cycle");
endmodule : bkm_monitor

// ==== test/bkm_breaker_model.sv ====
// Purpose: Breaker relays and feedback contact seen from the monitor
// Assumes: Feedback high while the breaker is open, breaker starts open
// Notes:   stuck ignores every command, slow stretches the contact travel
`timescale 1ns/1ps
module bkm_breaker_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic breakerCloseCommand,
    input  wire logic breakerOpenCommand,
    input  wire logic stuck,
    input  wire logic slow,
    output logic      breakerOpenFeedback
);
    // ==========================================================
    // Contact travel
    logic       target_r;
    logic [5:0] travel_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            breakerOpenFeedback <= 1'b1;
            target_r            <= 1'b1;
            travel_r            <= 6'h00;
        end else if (!stuck && (breakerOpenCommand || breakerCloseCommand)) begin
            // Open wins when both arrive, as a trip-free mechanism does
            target_r <= breakerOpenCommand;
            travel_r <= slow ? 6'h1E : 6'h03;
        end else if (travel_r != 6'h00) begin
            travel_r <= travel_r - 6'h01;
            if (travel_r == 6'h01) begin
                breakerOpenFeedback <= target_r;
            end
        end
    end
endmodule : bkm_breaker_model

// ==== test/breaker_and_phase_rotation_monitor_tb_top.sv ====
// Purpose: Self-checking bench of the breaker and phase rotation monitor
// Assumes: Tick shortened to 4 cycles, so 500 ticks are 2000 cycles
// Notes:   Rotation expectations come from a reference function
`timescale 1ns/1ps
module breaker_and_phase_rotation_monitor_tb_top import bkm_pkg::*; ;
    logic             core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata;
    logic             pready, pslverr, fb, closeCmd, openCmd, irq;
    logic             closeRequest = 1'b0, openRequest = 1'b0, lockMonitoring = 1'b0, extAck = 1'b0;
    logic             measuredReverse = 1'b0, voltageAboveHalf = 1'b0, stuck = 1'b0, slow = 1'b0;
    logic [ALM_W-1:0] alarms;
    bkm_class_t       rotAlarmClass, brkAlarmClass;
    int               badCount = 0, checksDone = 0, cycles = 0;

    bkm_monitor #(.TICK_LEN(4)) DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .closeRequest(closeRequest), .openRequest(openRequest), .breakerOpenFeedback(fb),
        .lockMonitoring(lockMonitoring), .extAck(extAck), .measuredReverse(measuredReverse),
        .voltageAboveHalf(voltageAboveHalf), .breakerCloseCommand(closeCmd), .breakerOpenCommand(openCmd),
        .alarms(alarms), .rotAlarmClass(rotAlarmClass), .brkAlarmClass(brkAlarmClass), .irq(irq));

    bkm_breaker_model brk (.core_clk(core_clk), .rst_n(rst_n), .breakerCloseCommand(closeCmd),
        .breakerOpenCommand(openCmd), .stuck(stuck), .slow(slow), .breakerOpenFeedback(fb));

    // ==========================================================
    // Helpers
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic wrapUp;
        if (badCount == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrapUp

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            $display("mismatch at %0t: run hung", $time);
            wrapUp();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: %s got %0h want %0h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic waitCyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : waitCyc

    // Holds the request until pready is seen high, then idles one cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(n < 16), 32'h1, "pready missing");
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, msg);
    endtask : rdChk

    task automatic pulseReq(input logic openSeq);
        if (openSeq) openRequest <= 1'b1;
        else closeRequest <= 1'b1;
        @(posedge core_clk);
        openRequest  <= 1'b0;
        closeRequest <= 1'b0;
        @(posedge core_clk);
        chk(32'({openCmd, closeCmd}), openSeq ? 32'h2 : 32'h1, "command relay");
    endtask : pulseReq

    task automatic ackPulse;
        extAck <= 1'b1;
        @(posedge core_clk);
        extAck <= 1'b0;
        waitCyc(2);
    endtask : ackPulse

    function automatic logic rotFault(input logic [31:0] c, input logic mr, input logic va, input logic lk);
        logic act;
        act = c[0] && !(c[4] && lk);
        if (c[7]) return act && (c[8] != c[1]);
        return act && va && (mr != c[1]);
    endfunction : rotFault

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] q, c;
        logic        e;
        int          n;
        void'($urandom(49830));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdChk(ADDR_CTRL, 32'h0003_2404, "ctrl reset");
        rdChk(ADDR_OPEN_TMO, {23'h0, OPEN_TMO_RST}, "timeout reset");
        chk(32'(rotAlarmClass), 32'(CLS_B), "rot class reset");
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk(32'(e), 32'h1, "unmapped error");
        n = $urandom_range(10, 1);
        stuck <= 1'b1;
        wr(ADDR_CTRL, 32'h0000_2004 | (n << 16));
        repeat (n - 1) pulseReq(1'b0);
        waitCyc(2);
        chk(32'(alarms[ALM_CLOSE]), 32'h0, "early close alarm");
        pulseReq(1'b0);
        waitCyc(2);
        chk(32'(alarms[ALM_CLOSE]), 32'h1, "close alarm");
        rdChk(ADDR_STATUS, (n << 8) | 32'h2, "attempts");
        stuck <= 1'b0;
        pulseReq(1'b0);
        waitCyc(1900);
        rdChk(ADDR_STATUS, ((n + 1) << 8) | 32'h2, "count kept");
        waitCyc(200);
        rdChk(ADDR_STATUS, 32'h2, "count cleared, alarm latched");
        ackPulse();
        chk(32'(alarms[ALM_CLOSE]), 32'h0, "ext ack");
        wr(ADDR_OPEN_TMO, 32'd501);
        rdChk(ADDR_OPEN_TMO, {23'h0, OPEN_TMO_RST}, "timeout refused");
        wr(ADDR_OPEN_TMO, {23'h0, OPEN_TMO_MIN});
        rdChk(ADDR_OPEN_TMO, {23'h0, OPEN_TMO_MIN}, "timeout min");
        stuck <= 1'b1;
        pulseReq(1'b1);
        waitCyc(30);
        chk(32'(alarms[ALM_OPEN]), 32'h0, "open alarm early");
        waitCyc(20);
        chk(32'(alarms[ALM_OPEN]), 32'h1, "open alarm");
        chk(32'(irq), 32'h0, "irq masked");
        wr(ADDR_IRQ_MASK, 32'h4);
        waitCyc(2);
        chk(32'(irq), 32'h1, "irq raised");
        rdChk(ADDR_IRQ_STAT, 32'h6, "irq status");
        wr(ADDR_IRQ_STAT, 32'h4);
        waitCyc(2);
        chk(32'(irq), 32'h0, "irq cleared");
        stuck <= 1'b0;
        slow  <= 1'b1;
        pulseReq(1'b1);
        waitCyc(60);
        chk(32'(alarms[ALM_OPEN]), 32'h1, "open latched");
        wr(ADDR_ACK, 32'h1);
        waitCyc(2);
        chk(32'(alarms[ALM_OPEN]), 32'h0, "manual ack, slow open ok");
        for (int i = 0; i < 24; i++) begin
            c = 32'h0003_2008 | ($urandom & 32'h0000_0193);
            wr(ADDR_CTRL, c);
            measuredReverse  <= 1'($urandom);
            voltageAboveHalf <= 1'($urandom);
            lockMonitoring   <= 1'($urandom);
            waitCyc(3);
            chk(32'(alarms[ALM_ROT]), 32'(rotFault(c, measuredReverse, voltageAboveHalf, lockMonitoring)),
                "rotation");
        end
        wr(ADDR_CTRL, 32'h0003_2001);
        lockMonitoring   <= 1'b0;
        voltageAboveHalf <= 1'b1;
        measuredReverse  <= 1'b1;
        waitCyc(3);
        chk(32'(alarms[ALM_ROT]), 32'h1, "rotation alarm");
        measuredReverse <= 1'b0;
        waitCyc(3);
        chk(32'(alarms[ALM_ROT]), 32'h1, "rotation latched");
        ackPulse();
        chk(32'(alarms[ALM_ROT]), 32'h0, "rotation ack");
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_CTRL, 32'h0003_0004 | (k << 10));
            waitCyc(1);
            chk(32'(rotAlarmClass), (k < 7) ? k : 6, "rot class");
            chk(32'(brkAlarmClass), 32'(CLS_A), "brk class");
        end
        wr(ADDR_CTRL, 32'h0001_2000);
        stuck <= 1'b1;
        pulseReq(1'b0);
        waitCyc(2);
        chk(32'(alarms[ALM_CLOSE]), 32'h0, "supervision off");
        wrapUp();
    end
endmodule : breaker_and_phase_rotation_monitor_tb_top
